/* rtl/rtc_irq_status.sv */
// Interrupt flags, battery status, century, oscillator control and
// square-wave/periodic rate selection, reached over the multiplexed bus.
// Assumes bus pins and the oscillator tick are asynchronous, while the
// alarm, update and year-rollover events come from logic on clk.
`timescale 1ns/1ps
`include "rtc_regs.svh"
module rtc_irq_status (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic chip_select_n,
    input wire logic addr_strobe,
    input wire logic data_strobe,
    input wire logic read_not_write,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe,
    input wire logic osc_tick,
    input wire logic backup_supply_pin,
    input wire logic alarm_match,
    input wire logic update_done,
    input wire logic year_rollover,
    input wire logic update_in_progress,
    output logic irq_n,
    output logic square_out_pin,
    output logic osc_enable,
    output logic update_inhibit
);
    import rtc_pkg::*;

    localparam int NS = 14;
    localparam logic [NS-1:0] KEEP_BATT = 14'h1000;

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [NS-1:0] pin_raw;
    logic [NS-1:0] s1;
    logic [NS-1:0] s2;
    logic [NS-1:0] s3;
    logic [NS-1:0] filt;
    logic [NS-1:0] filt_q;
    logic [NS-1:0] next_filt;

    assign pin_raw = {osc_tick, backup_supply_pin, read_not_write, data_strobe,
                      addr_strobe, chip_select_n, ad_in};

    // A bit changes only once the second and third stages agree
    always_comb
    begin
        next_filt = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & filt);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            s1 <= pin_raw & KEEP_BATT;
            s2 <= s1 & KEEP_BATT;
            s3 <= s2 & KEEP_BATT;
            filt <= next_filt & KEEP_BATT;
            filt_q <= filt & KEEP_BATT;
        end
        else if (ce)
        begin
            s1 <= pin_raw;
            s2 <= s1;
            s3 <= s2;
            filt <= next_filt;
            filt_q <= filt;
        end
    end

    logic [7:0] ad_f;
    logic cs_f;
    logic rw_f;
    logic battery_valid;
    logic as_fall;
    logic ds_rise;
    logic ds_fall;
    logic tick_rise;

    assign ad_f = filt[7:0];
    assign cs_f = ~filt[8];
    assign as_fall = filt_q[9] & ~filt[9];
    assign ds_rise = ~filt_q[10] & filt[10];
    assign ds_fall = filt_q[10] & ~filt[10];
    assign rw_f = filt[11];
    assign battery_valid = filt[12];
    assign tick_rise = ~filt_q[13] & filt[13];

    // ****************************************************************
    // Divider chain
    // ****************************************************************
    rtc_div_if div_link ();

    rtc_divtap #(
        .STAGES(`RTC_DIV_STAGES)
    ) u_divtap (
        .clk(clk),
        .reset_n(reset_n),
        .ce(ce),
        .dv(div_link.div)
    );

    // ****************************************************************
    // Host bus sequencer
    // ****************************************************************
    rtc_bus_e bus_st;
    rtc_bus_e next_bus_st;
    logic [6:0] addr;
    logic [6:0] next_addr;
    logic [7:0] rd_data;
    logic [7:0] next_rd_data;
    logic [7:0] read_mux;
    logic wr_strobe;
    logic clear_flags;

    always_comb
    begin
        next_bus_st = bus_st;
        next_addr = addr;
        next_rd_data = rd_data;
        wr_strobe = 1'b0;
        clear_flags = 1'b0;
        if (as_fall)
            next_addr = ad_f[6:0];
        unique case (bus_st)
            RTC_BUS_IDLE:
            begin
                if (ds_rise && cs_f)
                begin
                    if (rw_f)
                    begin
                        next_bus_st = RTC_BUS_READ;
                        next_rd_data = read_mux;
                    end
                    else
                        next_bus_st = RTC_BUS_WRITE;
                end
            end
            RTC_BUS_READ:
            begin
                if (ds_fall)
                begin
                    next_bus_st = RTC_BUS_IDLE;
                    clear_flags = (addr == `RTC_OFS_FLAGS);
                end
            end
            RTC_BUS_WRITE:
            begin
                if (ds_fall)
                begin
                    next_bus_st = RTC_BUS_IDLE;
                    wr_strobe = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            bus_st <= RTC_BUS_IDLE;
            addr <= '0;
            rd_data <= '0;
        end
        else if (ce)
        begin
            bus_st <= next_bus_st;
            addr <= next_addr;
            rd_data <= next_rd_data;
        end
    end

    assign ad_out = rd_data;
    assign ad_oe = (bus_st == RTC_BUS_READ);

    // ****************************************************************
    // Control registers and event flags
    // ****************************************************************
    logic [2:0] osc_div;
    logic [2:0] next_osc_div;
    rtc_rate_t rate_select;
    rtc_rate_t next_rate_select;
    logic [7:0] ctrl;
    logic [7:0] next_ctrl;
    logic [7:0] century_count;
    logic [7:0] next_century_count;
    logic [2:0] flags;
    logic [2:0] next_flags;
    logic [2:0] pend;
    logic [2:0] next_pend;
    logic [2:0] events;
    logic [2:0] enables;
    logic [2:0] next_enables;
    logic irq_summary_flag;
    logic next_irq_summary;
    logic next_square;
    logic reading_flags;
    rtc_osc_e osc_mode;

    assign events = {div_link.tap_rise, alarm_match, update_done};
    assign enables = {ctrl[`RTC_FLD_PIE], ctrl[`RTC_FLD_AIE], ctrl[`RTC_FLD_UIE]};
    assign next_enables = {next_ctrl[`RTC_FLD_PIE], next_ctrl[`RTC_FLD_AIE], next_ctrl[`RTC_FLD_UIE]};
    assign irq_summary_flag = |(flags & enables);
    assign reading_flags = ((bus_st == RTC_BUS_READ) || (next_bus_st == RTC_BUS_READ))
                           && (addr == `RTC_OFS_FLAGS);

    always_comb
    begin
        if (osc_div == `RTC_DIV_RUN)
            osc_mode = RTC_OSC_RUN;
        else if (osc_div[2:1] == `RTC_DIV_HOLD)
            osc_mode = RTC_OSC_HOLD;
        else
            osc_mode = RTC_OSC_OFF;
    end

    always_comb
    begin
        next_osc_div = osc_div;
        next_rate_select = rate_select;
        next_ctrl = ctrl;
        next_century_count = century_count;
        next_flags = flags;
        next_pend = pend;
        if (wr_strobe && addr == `RTC_OFS_RATE)
        begin
            next_osc_div = ad_f[6:4];
            next_rate_select = ad_f[3:0];
        end
        if (wr_strobe && addr == `RTC_OFS_CTRL)
        begin
            next_ctrl = ad_f;
            if (ad_f[`RTC_FLD_SET])
                next_ctrl[`RTC_FLD_UIE] = 1'b0;
        end
        if (wr_strobe && addr == `RTC_OFS_CENTURY)
            next_century_count = ad_f;
        if (year_rollover)
            next_century_count = {next_century_count[7], `RTC_CENTURY_LOAD};
        // Events set flags whatever the enables; during a flag read they wait
        if (clear_flags)
        begin
            next_flags = pend | events;
            next_pend = '0;
        end
        else if (reading_flags)
            next_pend = pend | events;
        else
            next_flags = flags | events;
        next_irq_summary = |(next_flags & next_enables);
        next_square = ctrl[`RTC_FLD_SQUARE_OUT_ENABLE] & div_link.tap_level;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            osc_div <= `RTC_DIV_RST;
            rate_select <= `RTC_RATE_RST;
            ctrl <= `RTC_CTRL_RST;
            century_count <= `RTC_CENTURY_RST;
            flags <= '0;
            pend <= '0;
            irq_n <= 1'b1;
            square_out_pin <= 1'b0;
        end
        else if (ce)
        begin
            osc_div <= next_osc_div;
            rate_select <= next_rate_select;
            ctrl <= next_ctrl;
            century_count <= next_century_count;
            flags <= next_flags;
            pend <= next_pend;
            irq_n <= ~next_irq_summary;
            square_out_pin <= next_square;
        end
    end

    assign div_link.tick = tick_rise;
    assign div_link.mode = osc_mode;
    assign div_link.rate = rate_select;
    assign osc_enable = (osc_mode != RTC_OSC_OFF);
    assign update_inhibit = ctrl[`RTC_FLD_SET];

    // ****************************************************************
    // General purpose memory
    // ****************************************************************
    logic [7:0] mem [0:127];
    logic is_mem;

    assign is_mem = (addr > `RTC_OFS_BATT) && (addr != `RTC_OFS_CENTURY);

    // Not gated by update activity: always open to the host
    always_ff @(posedge clk)
    begin
        if (ce && wr_strobe && is_mem)
            mem[addr] <= ad_f;
    end

    // ****************************************************************
    // Read data selection
    // ****************************************************************
    always_comb
    begin
        read_mux = 8'h00;
        if (addr == `RTC_OFS_RATE)
            read_mux = {update_in_progress, osc_div, rate_select};
        else if (addr == `RTC_OFS_CTRL)
            read_mux = ctrl;
        else if (addr == `RTC_OFS_FLAGS)
            read_mux = {irq_summary_flag, flags, 4'h0};
        else if (addr == `RTC_OFS_BATT)
            read_mux = {battery_valid, 7'h00};
        else if (addr == `RTC_OFS_CENTURY)
            read_mux = century_count;
        else if (is_mem)
            read_mux = mem[addr];
    end
endmodule

/* rtl/rtc_regs.svh */
// Register offsets, field positions, reset values and pattern codes
// of the interrupt, status and divider-select block.
// Assumes 7-bit register addresses on the multiplexed host bus.
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define RTC_OFS_TIME_LAST 7'h09
`define RTC_OFS_RATE 7'h0a
`define RTC_OFS_CTRL 7'h0b
`define RTC_OFS_FLAGS 7'h0c
`define RTC_OFS_BATT 7'h0d
`define RTC_OFS_CENTURY 7'h32

// ****************************************************************
// Field positions
// ****************************************************************
`define RTC_FLD_IRQ_SUMMARY_FLAG 7
`define RTC_FLD_UIP 7
`define RTC_FLD_VALID 7
`define RTC_FLD_SET 7
`define RTC_FLD_PIE 6
`define RTC_FLD_AIE 5
`define RTC_FLD_UIE 4
`define RTC_FLD_SQUARE_OUT_ENABLE 3

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define RTC_CTRL_RST 8'h00
`define RTC_DIV_RST 3'h0
`define RTC_RATE_RST 4'h0
`define RTC_CENTURY_RST 8'h20
`define RTC_CENTURY_LOAD 7'h20
`define RTC_DIV_RUN 3'h2
`define RTC_DIV_HOLD 2'h3
`define RTC_DIV_STAGES 15

`endif

/* rtl/rtc_pkg.sv */
// Types shared by the interrupt/status block and its divider.
// Assumes rtc_regs.svh supplies the numeric constants.
package rtc_pkg;
    typedef enum logic [1:0] {RTC_OSC_OFF, RTC_OSC_HOLD, RTC_OSC_RUN} rtc_osc_e;
    typedef enum logic [1:0] {RTC_BUS_IDLE, RTC_BUS_READ, RTC_BUS_WRITE} rtc_bus_e;
    typedef logic [3:0] rtc_rate_t;
endpackage

/* rtl/rtc_div_if.sv */
// Link between the register block and the divider chain.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface rtc_div_if;
    import rtc_pkg::*;
    logic tick;
    rtc_osc_e mode;
    rtc_rate_t rate;
    logic tap_level;
    logic tap_rise;
    modport ctl (output tick, output mode, output rate, input tap_level, input tap_rise);
    modport div (input tick, input mode, input rate, output tap_level, output tap_rise);
endinterface

/* rtl/rtc_divtap.sv */
// Divider chain with the 1-of-15 tap selector.
// Assumes tick is a one-cycle pulse per oscillator period.
`timescale 1ns/1ps
`include "rtc_regs.svh"
module rtc_divtap #(
    parameter int STAGES = `RTC_DIV_STAGES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    rtc_div_if.div dv
);
    import rtc_pkg::*;

    if (STAGES != `RTC_DIV_STAGES)
    begin : g_chk
        $error("rtc_divtap serves only a fifteen-stage chain");
    end

    logic [STAGES-1:0] chain;
    logic [STAGES-1:0] next_chain;
    logic tap_q;
    logic next_tap;

    // ****************************************************************
    // Tap selection: code 0 disables, 1..2 repeat the taps of 8..9, 3..15 run from fastest to slowest
    // ****************************************************************
    function automatic logic pick_tap(input rtc_rate_t rs, input logic [STAGES-1:0] c);
        logic t;
        t = 1'b0;
        if (rs == 4'h1)
            t = c[6];
        else if (rs == 4'h2)
            t = c[7];
        else if (rs >= 4'h3)
            t = c[4'(rs - 4'h2)];
        return t;
    endfunction

    always_comb
    begin
        next_chain = chain;
        unique case (dv.mode)
            RTC_OSC_RUN:
            begin
                if (dv.tick)
                    next_chain = chain + 1'b1;
            end
            RTC_OSC_HOLD: next_chain = '0;
            RTC_OSC_OFF: next_chain = chain;
        endcase
        next_tap = pick_tap(dv.rate, chain);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            chain <= '0;
            tap_q <= 1'b0;
        end
        else if (ce)
        begin
            chain <= next_chain;
            tap_q <= next_tap;
        end
    end

    assign dv.tap_level = next_tap;
    assign dv.tap_rise = next_tap & ~tap_q;
endmodule

/* tb/rtc_irq_status_sva.sv */
// Concurrent checks on the pins of the interrupt/status block.
// Assumes it is bound to rtc_irq_status and sees only its ports.
`timescale 1ns/1ps
`include "rtc_regs.svh"
module rtc_irq_status_sva (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic ce,
    input wire logic chip_select_n,
    input wire logic addr_strobe,
    input wire logic data_strobe,
    input wire logic read_not_write,
    input wire logic [7:0] ad_in,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic osc_tick,
    input wire logic backup_supply_pin,
    input wire logic alarm_match,
    input wire logic update_done,
    input wire logic year_rollover,
    input wire logic update_in_progress,
    input wire logic irq_n,
    input wire logic square_out_pin,
    input wire logic osc_enable,
    input wire logic update_inhibit
);
    logic [6:0] addr;
    logic [6:0] next_addr;
    logic as_q;
    logic next_as_q;

    // Address seen on the bus when the address strobe falls
    always_comb
    begin
        next_as_q = addr_strobe;
        next_addr = (as_q && !addr_strobe) ? ad_in[6:0] : addr;
    end

    always_ff @(posedge clk)
    begin
        as_q <= next_as_q;
        addr <= next_addr;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_OE_CAUSE: assert property ($rose(ad_oe) |-> $past(data_strobe, 4) && !$past(chip_select_n, 4)
        && $past(read_not_write, 4)) else $error("bus driven without a read strobe");
    AST_OE_DROP: assert property ($fell(data_strobe) |-> ##[1:8] !ad_oe)
        else $error("bus still driven after strobe end");
    AST_DATA_STABLE: assert property (ad_oe && $past(ad_oe) |-> $stable(ad_out))
        else $error("read data moved during read");
    AST_RESET_QUIET: assert property ($rose(reset_n) |-> irq_n && !ad_oe && !square_out_pin
        && !osc_enable && !update_inhibit) else $error("outputs not quiet after reset");
    AST_IRQ_RELEASE: assert property ($rose(irq_n) |-> !$past(data_strobe, 4))
        else $error("interrupt released before strobe end");
    AST_SQUARE_OSC: assert property ($rose(square_out_pin) |-> osc_enable)
        else $error("square output moved with oscillator off");
    AST_FLAGS_LOW: assert property (ad_oe && addr == `RTC_OFS_FLAGS |-> ad_out[3:0] == 4'h0)
        else $error("flag register low bits not zero");
    AST_BATT_LOW: assert property (ad_oe && addr == `RTC_OFS_BATT |-> ad_out[6:0] == 7'h00)
        else $error("battery register low bits not zero");
    AST_SUMMARY: assert property ($rose(ad_oe) && addr == `RTC_OFS_FLAGS |-> ad_out[7] == !irq_n)
        else $error("summary bit disagrees with interrupt pin");
endmodule

bind rtc_irq_status rtc_irq_status_sva u_sva (.clk, .reset_n, .ce, .chip_select_n, .addr_strobe, .data_strobe,
    .read_not_write, .ad_in, .ad_out, .ad_oe, .osc_tick, .backup_supply_pin, .alarm_match, .update_done,
    .year_rollover, .update_in_progress, .irq_n, .square_out_pin, .osc_enable, .update_inhibit);

/* tb/rtc_host_bfm.sv */
// Host processor model on the multiplexed address/data pins.
// Assumes the block filters its pins, so each phase is held several clocks.
`timescale 1ns/1ps
module rtc_host_bfm (
    input wire logic clk,
    input wire logic ad_oe,
    input wire logic [7:0] ad_out,
    output logic chip_select_n,
    output logic addr_strobe,
    output logic data_strobe,
    output logic read_not_write,
    output logic [7:0] host_ad
);
    initial
    begin
        chip_select_n = 1'b1;
        addr_strobe = 1'b0;
        data_strobe = 1'b0;
        read_not_write = 1'b1;
        host_ad = 8'h00;
    end

    // One byte access: address phase, then data phase
    task access(input logic [6:0] a, input logic wr, input logic [7:0] wd, output logic [7:0] rd);
        int n;
        n = 0;
        rd = 'x;
        @(posedge clk);
        host_ad <= {1'b0, a};
        chip_select_n <= 1'b0;
        read_not_write <= !wr;
        addr_strobe <= 1'b1;
        repeat (6) @(posedge clk);
        addr_strobe <= 1'b0;
        repeat (6) @(posedge clk);
        // On a read the host lets go of the bus, so its own value turns over
        host_ad <= wr ? wd : ~{1'b0, a};
        data_strobe <= 1'b1;
        while (!wr && ad_oe !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        repeat (8) @(posedge clk);
        if (!wr && ad_oe === 1'b1)
            rd = ad_out;
        data_strobe <= 1'b0;
        repeat (8) @(posedge clk);
        host_ad <= ~host_ad;
        chip_select_n <= 1'b1;
        read_not_write <= 1'b1;
    endtask
endmodule

/* tb/test_rtc_irq_status.sv */
// Self-checking bench for the interrupt/status block.
// Assumes rtc_host_bfm drives the bus and events come on the same clock.
`timescale 1ns/1ps
`include "rtc_regs.svh"
module test_rtc_irq_status;
    logic clk, reset_n, osc_tick, backup, uip, osc_run, sq_q;
    logic cs_n, as_p, ds_p, rnw, ad_oe, irq_n, sq, osc_en, uinh;
    logic [2:0] ev;
    logic [7:0] host_ad, ad_out, ad_bus, v;
    int fails, n_checks, cyc, sq_rises, tk, n;

    assign ad_bus = ad_oe ? ad_out : host_ad;

    rtc_irq_status u_dut (.clk(clk), .reset_n(reset_n), .ce(1'b1), .chip_select_n(cs_n),
        .addr_strobe(as_p), .data_strobe(ds_p), .read_not_write(rnw), .ad_in(ad_bus), .ad_out(ad_out),
        .ad_oe(ad_oe), .osc_tick(osc_tick), .backup_supply_pin(backup), .alarm_match(ev[0]),
        .update_done(ev[1]), .year_rollover(ev[2]), .update_in_progress(uip), .irq_n(irq_n),
        .square_out_pin(sq), .osc_enable(osc_en), .update_inhibit(uinh));
    rtc_host_bfm u_host (.clk(clk), .ad_oe(ad_oe), .ad_out(ad_out), .chip_select_n(cs_n),
        .addr_strobe(as_p), .data_strobe(ds_p), .read_not_write(rnw), .host_ad(host_ad));

    task summarize;
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task rd(input logic [6:0] a, input logic [7:0] exp);
        u_host.access(a, 1'b0, 8'h00, v);
        chk(v, exp);
    endtask

    task wr(input logic [6:0] a, input logic [7:0] d);
        u_host.access(a, 1'b1, d, v);
    endtask

    task pulse(input logic [2:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 3'h0;
        @(posedge clk);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Oscillator input, square-wave edge count and run limit
    always @(posedge clk)
    begin
        cyc++;
        tk++;
        sq_q <= sq;
        if (sq && !sq_q)
            sq_rises++;
        if (tk == 5)
        begin
            tk = 0;
            osc_tick <= osc_run ? ~osc_tick : osc_tick;
        end
        if (cyc == 20000)
        begin
            fails++;
            summarize();
        end
    end

    initial
    begin
        reset_n = 1'b0;
        osc_tick = 1'b0;
        backup = 1'b1;
        uip = 1'b0;
        osc_run = 1'b0;
        ev = 3'h0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`RTC_OFS_FLAGS, 8'h00);
        rd(`RTC_OFS_BATT, 8'h80);
        rd(`RTC_OFS_CENTURY, 8'h20);
        chk({7'h0, osc_en}, 8'h00);
        wr(`RTC_OFS_FLAGS, 8'hff);
        wr(`RTC_OFS_BATT, 8'hff);
        rd(`RTC_OFS_FLAGS, 8'h00);
        rd(`RTC_OFS_BATT, 8'h80);
        backup <= 1'b0;
        rd(`RTC_OFS_BATT, 8'h00);
        backup <= 1'b1;
        pulse(3'h1);
        chk({7'h0, irq_n}, 8'h01);
        rd(`RTC_OFS_FLAGS, 8'h20);
        rd(`RTC_OFS_FLAGS, 8'h00);
        pulse(3'h2);
        wr(`RTC_OFS_CTRL, 8'h10);
        chk({7'h0, irq_n}, 8'h00);
        rd(`RTC_OFS_FLAGS, 8'h90);
        chk({7'h0, irq_n}, 8'h01);
        // An alarm landing inside a flag read waits for the next read
        fork
            rd(`RTC_OFS_FLAGS, 8'h00);
            begin
                repeat (19) @(posedge clk);
                pulse(3'h1);
            end
        join
        rd(`RTC_OFS_FLAGS, 8'h20);
        wr(`RTC_OFS_CTRL, 8'h90);
        rd(`RTC_OFS_CTRL, 8'h80);
        chk({7'h0, uinh}, 8'h01);
        wr(`RTC_OFS_CTRL, 8'h00);
        wr(`RTC_OFS_CENTURY, 8'h85);
        pulse(3'h4);
        rd(`RTC_OFS_CENTURY, 8'ha0);
        wr(`RTC_OFS_CENTURY, 8'h19);
        pulse(3'h4);
        rd(`RTC_OFS_CENTURY, 8'h20);
        uip <= 1'b1;
        wr(7'h40, 8'h5a);
        rd(7'h40, 8'h5a);
        rd(`RTC_OFS_RATE, 8'h80);
        uip <= 1'b0;
        for (int p = 0; p < 8; p++)
        begin
            wr(`RTC_OFS_RATE, {1'b0, p[2:0], 4'h3});
            chk({7'h0, osc_en}, {7'h0, (p == 2 || p >= 6)});
        end
        // Fastest tap drives both the flag and the square output
        osc_run <= 1'b1;
        wr(`RTC_OFS_RATE, 8'h23);
        u_host.access(`RTC_OFS_FLAGS, 1'b0, 8'h00, v);
        sq_rises = 0;
        wr(`RTC_OFS_CTRL, 8'h48);
        n = 0;
        while (irq_n !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        chk({7'h0, irq_n}, 8'h00);
        rd(`RTC_OFS_FLAGS, 8'hc0);
        chk({7'h0, sq_rises > 0}, 8'h01);
        wr(`RTC_OFS_RATE, 8'h20);
        u_host.access(`RTC_OFS_FLAGS, 1'b0, 8'h00, v);
        repeat (200) @(posedge clk);
        rd(`RTC_OFS_FLAGS, 8'h00);
        chk({7'h0, sq}, 8'h00);
        wr(`RTC_OFS_RATE, 8'h23);
        wr(`RTC_OFS_CTRL, 8'h40);
        sq_rises = 0;
        repeat (200) @(posedge clk);
        chk({7'h0, sq_rises > 0}, 8'h00);
        chk({7'h0, irq_n}, 8'h00);
        wr(`RTC_OFS_RATE, 8'h63);
        u_host.access(`RTC_OFS_FLAGS, 1'b0, 8'h00, v);
        repeat (200) @(posedge clk);
        rd(`RTC_OFS_FLAGS, 8'h00);
        wr(`RTC_OFS_CTRL, 8'h20);
        pulse(3'h1);
        chk({7'h0, irq_n}, 8'h00);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`RTC_OFS_CTRL, 8'h00);
        rd(`RTC_OFS_RATE, 8'h00);
        chk({7'h0, irq_n}, 8'h01);
        rd(`RTC_OFS_FLAGS, 8'h00);
        rd(`RTC_OFS_BATT, 8'h80);
        summarize();
    end
endmodule
